// *** rtl/fdcsc_pkg.sv ***
`default_nettype none
package fdcsc_pkg;
  localparam logic [4:0] OP_SCAN_EQ  = 5'h11;
  localparam logic [4:0] OP_SCAN_LE  = 5'h19;
  localparam logic [4:0] OP_SCAN_HE  = 5'h1D;
  localparam logic [7:0] OP_SEEK     = 8'h0F;
  localparam int         FLAG_MT_BIT = 7;
  localparam int         FLAG_DD_BIT = 6;
  localparam int         FLAG_SK_BIT = 5;
  localparam int         ST2_SAT_BIT = 3;
  localparam int         ST2_NOT_BIT = 2;
  localparam int         ST0_SEEK_END_BIT = 5;
  localparam int         ST0_IC_ABN  = 6;
  localparam logic [7:0] WILDCARD    = 8'hFF;
  localparam int         CMD_BYTES   = 9;
  localparam int         RES_BYTES   = 7;
  localparam int         STEP_TIME_NS = 3000;
  localparam int         CLK_NS      = 100;
  localparam int         STEP_CYC    = (STEP_TIME_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       deleted;
    logic       crc_err;
  } fdcsc_disk_type;
endpackage
`default_nettype wire

// *** rtl/fdcsc_core.sv ***
`default_nettype none
module fdcsc_core
  import fdcsc_pkg::*;
(
  input  wire logic           sys_clk_i,
  input  wire logic           reset_i,
  input  wire logic           cmd_valid_i,
  input  wire logic [7:0]     cmd_byte_i,
  output logic                cmd_ready_o,
  input  wire logic           disk_valid_i,
  input  wire fdcsc_disk_type disk_i,
  output logic                disk_ready_o,
  input  wire logic           host_valid_i,
  input  wire logic [7:0]     host_byte_i,
  output logic                host_ready_o,
  input  wire logic           terminal_count_in_i,
  input  wire logic           scan_wildcard_enable_i,
  input  wire logic [7:0]     present_track_i,
  output logic                sector_req_o,
  output logic [7:0]          sector_num_o,
  output logic                res_valid_o,
  output logic [7:0]          res_byte_o,
  input  wire logic           res_ready_i,
  output logic                step_o,
  output logic                step_dir_in_o,
  output logic [3:0]          drive_busy_o,
  output logic                seek_done_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_CMD = 3'b001, S_REQ = 3'b010, S_DATA = 3'b011,
    S_RES = 3'b100, S_SEEK = 3'b101
  } fdcsc_state_type;
  ////////////////////////////////////////////////////////////////////////
  // two-flop sync of terminal count pin
  logic tc_meta_reg, tc_sync_reg;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tc_meta_reg <= 1'b0;
      tc_sync_reg <= 1'b0;
    end else begin
      tc_meta_reg <= terminal_count_in_i;
      tc_sync_reg <= tc_meta_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // two-entry disk byte buffer
  fdcsc_disk_type buf_mem_reg [2];
  logic           wp_reg, rp_reg;
  logic [1:0]     cnt_reg;
  logic           buf_pop;
  wire            buf_push  = disk_valid_i && disk_ready_o;
  wire            buf_valid = (cnt_reg != 2'h0);
  fdcsc_disk_type buf_head;
  assign buf_head = buf_mem_reg[rp_reg];
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
      disk_ready_o <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_mem_reg[wp_reg] <= disk_i;
        wp_reg <= ~wp_reg;
      end
      if (buf_pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
      disk_ready_o <= (cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h2; // room next cycle
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] cmp_byte(input logic [7:0] d, input logic [7:0] h,
                                          input logic wild);
    // 00 equal, 01 disk less, 10 disk greater; unsigned
    if (wild && (d == WILDCARD || h == WILDCARD)) cmp_byte = 2'h0;
    else if (d == h) cmp_byte = 2'h0;
    else if (d < h) cmp_byte = 2'h1;
    else cmp_byte = 2'h2;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  fdcsc_state_type state_reg, state_next;
  logic [7:0] cmd_reg [CMD_BYTES];
  logic [3:0] idx_reg, idx_next;
  logic [1:0] ord_reg, ord_next;
  logic [7:0] sec_reg, sec_next, st1_reg, st1_next, st2_reg, st2_next;
  logic       any_read_reg, any_read_next;
  logic [7:0] trk_reg, trk_next;
  logic [7:0] tgt_reg;
  logic [$clog2(STEP_CYC+1)-1:0] tmr_reg, tmr_next;
  logic       step_next, done_next, cmd_ready_next, req_next, rv_next;
  logic [7:0] rb_next;
  logic [3:0] busy_next;
  logic       dir_next;
  wire [4:0]  opc    = cmd_reg[0][4:0];
  wire        is_eq  = (opc == OP_SCAN_EQ);
  wire        is_le  = (opc == OP_SCAN_LE);
  function automatic logic scan_sat(input logic [1:0] ord, input logic eq, input logic le);
    // equal always; less for low-or-equal, greater for high-or-equal
    scan_sat = (ord == 2'h0) || (le && ord == 2'h1) || (!eq && !le && ord == 2'h2);
  endfunction
  wire [1:0]  drv    = cmd_reg[1][1:0];
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    ord_next = ord_reg;
    sec_next = sec_reg;
    st1_next = st1_reg;
    st2_next = st2_reg;
    any_read_next = any_read_reg;
    trk_next = trk_reg;
    tmr_next = tmr_reg;
    step_next = 1'b0;
    done_next = 1'b0;
    cmd_ready_next = 1'b0;
    req_next = 1'b0;
    rv_next = res_valid_o;
    rb_next = res_byte_o;
    busy_next = drive_busy_o;
    dir_next = step_dir_in_o;
    buf_pop = 1'b0;
    host_ready_o = 1'b0;
    case (state_reg)
      S_IDLE: begin
        cmd_ready_next = 1'b1;
        idx_next = 4'h0;
        if (cmd_valid_i && cmd_ready_o) begin
          state_next = S_CMD;
          idx_next = 4'h1;
        end
      end
      S_CMD: begin
        cmd_ready_next = 1'b1;
        if (cmd_valid_i && cmd_ready_o) begin
          idx_next = idx_reg + 4'h1;
          if (cmd_reg[0] == OP_SEEK && idx_reg == 4'h2) begin
            state_next = S_SEEK;
            cmd_ready_next = 1'b0;
            trk_next = present_track_i;
            busy_next[drv] = 1'b1;
          end else if (idx_reg == 4'(CMD_BYTES - 1)) begin
            state_next = S_REQ;
            cmd_ready_next = 1'b0;
            sec_next = cmd_reg[4];
            st1_next = 8'h00;
            st2_next = 8'h00;
            any_read_next = 1'b0;
          end
        end
      end
      S_REQ: begin
        req_next = 1'b1;
        ord_next = 2'h0;
        state_next = S_DATA;
      end
      S_DATA: begin
        if (buf_valid && (host_valid_i || buf_head.deleted)) begin
          buf_pop = 1'b1;
          host_ready_o = !buf_head.deleted;
          if (buf_head.crc_err) st1_next[5] = 1'b1;
          if (!buf_head.deleted && ord_reg == 2'h0)
            ord_next = cmp_byte(buf_head.data, host_byte_i, scan_wildcard_enable_i);
          if (buf_head.last) begin
            idx_next = 4'h0;
            if (buf_head.crc_err || st1_reg[5]) begin
              state_next = S_RES;
            end else if (buf_head.deleted && cmd_reg[0][FLAG_SK_BIT]) begin
              if (sec_reg >= cmd_reg[6] || tc_sync_reg) begin
                state_next = S_RES;
                if (!any_read_reg) st2_next[ST2_SAT_BIT] = 1'b1;
              end else begin
                sec_next = sec_reg + cmd_reg[8];
                state_next = S_REQ;
              end
            end else begin
              any_read_next = 1'b1;
              if (scan_sat(ord_next, is_eq, is_le) || sec_reg >= cmd_reg[6]
                  || tc_sync_reg) begin
                state_next = S_RES;
                st2_next[ST2_SAT_BIT] = (ord_next == 2'h0);
                st2_next[ST2_NOT_BIT] = !scan_sat(ord_next, is_eq, is_le);
              end else begin
                sec_next = sec_reg + cmd_reg[8];
                state_next = S_REQ;
              end
            end
          end
        end
      end
      S_RES: begin
        if (!res_valid_o || res_ready_i) begin
          rv_next = (idx_reg != 4'(RES_BYTES));
          case (idx_reg)
            4'h0: rb_next = {5'h00, cmd_reg[1][2:0]} | (8'(st1_reg[5]) << ST0_IC_ABN);
            4'h1: rb_next = st1_reg;
            4'h2: rb_next = st2_reg;
            4'h3: rb_next = cmd_reg[2];
            4'h4: rb_next = cmd_reg[3];
            4'h5: rb_next = sec_reg;
            4'h6: rb_next = cmd_reg[5];
            default: rb_next = 8'h00;
          endcase
          idx_next = idx_reg + 4'h1;
          if (idx_reg == 4'(RES_BYTES)) state_next = S_IDLE;
        end
      end
      S_SEEK: begin
        if (tmr_reg != '0) tmr_next = tmr_reg - 1'b1;
        else if (trk_reg == tgt_reg) begin
          busy_next[drv] = 1'b0;
          done_next = 1'b1;
          state_next = S_IDLE;
        end else begin
          step_next = 1'b1;
          dir_next = (tgt_reg > trk_reg);
          trk_next = (tgt_reg > trk_reg) ? trk_reg + 8'h01 : trk_reg - 8'h01;
          tmr_next = ($clog2(STEP_CYC+1))'(STEP_CYC);
        end
      end
      default: state_next = S_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= S_IDLE;
      idx_reg <= 4'h0;
      ord_reg <= 2'h0;
      sec_reg <= 8'h00;
      st1_reg <= 8'h00;
      st2_reg <= 8'h00;
      any_read_reg <= 1'b0;
      trk_reg <= 8'h00;
      tgt_reg <= 8'h00;
      tmr_reg <= '0;
      step_o <= 1'b0;
      seek_done_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      sector_req_o <= 1'b0;
      res_valid_o <= 1'b0;
      res_byte_o <= 8'h00;
      drive_busy_o <= 4'h0;
      step_dir_in_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      ord_reg <= ord_next;
      sec_reg <= sec_next;
      st1_reg <= st1_next;
      st2_reg <= st2_next;
      any_read_reg <= any_read_next;
      trk_reg <= trk_next;
      if (state_reg == S_CMD && cmd_reg[0] == OP_SEEK && cmd_valid_i && cmd_ready_o)
        tgt_reg <= cmd_byte_i;
      tmr_reg <= tmr_next;
      step_o <= step_next;
      seek_done_o <= done_next;
      cmd_ready_o <= cmd_ready_next;
      sector_req_o <= req_next;
      res_valid_o <= rv_next;
      res_byte_o <= rb_next;
      drive_busy_o <= busy_next;
      step_dir_in_o <= dir_next;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (cmd_valid_i && cmd_ready_o && (state_reg == S_IDLE || state_reg == S_CMD))
      cmd_reg[idx_reg] <= cmd_byte_i;
  end
  assign sector_num_o = sec_reg;
  ////////////////////////////////////////////////////////////////////////
  a_step_advance: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg == S_DATA && state_next == S_REQ |=> sec_reg == $past(sec_reg) + cmd_reg[8])
    else $error("sector step wrong");
  a_busy_on_seek: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg != S_SEEK ##1 state_reg == S_SEEK |-> drive_busy_o[drv])
    else $error("busy not set");
  a_step_gap: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    step_o |=> !step_o [*2]) else $error("steps too close");
  a_seek_reaches: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    seek_done_o |-> trk_reg == tgt_reg) else $error("seek ended off track");
  a_result_count: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg == S_RES |-> idx_reg <= 4'(RES_BYTES)) else $error("too many results");
  a_stat_excl: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !(st2_reg[ST2_SAT_BIT] && st2_reg[ST2_NOT_BIT])) else $error("both scan bits");
  a_wild_match: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg == S_DATA && buf_pop && !buf_head.deleted && ord_reg == 2'h0
    && scan_wildcard_enable_i && (buf_head.data == WILDCARD || host_byte_i == WILDCARD)
    |=> ord_reg == 2'h0) else $error("wildcard missed");
  a_tc_stop: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg == S_DATA && buf_pop && buf_head.last && tc_sync_reg
    |=> state_reg == S_RES) else $error("tc ignored");
endmodule
`default_nettype wire

// *** verification/fdcsc_disk_model.sv ***
`default_nettype none
module fdcsc_disk_model
  import fdcsc_pkg::*;
#(
  parameter int SEC_LEN = 4
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic          sector_req_i,
  input  wire logic          disk_ready_i,
  input  wire logic [7:0]    first_byte_i,
  input  wire logic [7:0]    rest_byte_i,
  input  wire logic          deleted_i,
  output var  logic          disk_valid_o,
  output var  fdcsc_disk_type disk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx;
  function automatic fdcsc_disk_type mk(input int i);
    return '{(i == 0) ? first_byte_i : rest_byte_i, i == SEC_LEN - 1, deleted_i, 1'b0};
  endfunction
  //////////////////////////////////////////////////////////////////////
  // one sector per request, leading byte first; released lines toggle
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      disk_valid_o <= 1'b0;
      disk_o <= '0;
    end else if (disk_valid_o && disk_ready_i) begin
      idx <= idx + 1;
      disk_valid_o <= (idx != SEC_LEN - 1);
      disk_o <= (idx == SEC_LEN - 1) ? ~disk_o : mk(idx + 1);
    end else if (!disk_valid_o && sector_req_i) begin
      idx <= 0;
      disk_valid_o <= 1'b1;
      disk_o <= mk(0);
    end else if (!disk_valid_o) begin
      disk_o <= ~disk_o;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top
  import fdcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 40000;
  logic sys_clk_i, reset_i, cmd_valid_i, cmd_ready_o, disk_valid_i, disk_ready_o;
  logic host_valid_i, host_ready_o, terminal_count_in_i, scan_wildcard_enable_i;
  logic sector_req_o, res_valid_o, res_ready_i, step_o, step_dir_in_o, seek_done_o;
  logic del, exp_dir, tc_arm;
  logic [7:0] cmd_byte_i, host_byte_i, present_track_i, sector_num_o, res_byte_o;
  logic [7:0] first_b, rest_b;
  logic [7:0] res [7];
  logic [7:0] sect_log [16];
  logic [3:0] drive_busy_o;
  fdcsc_disk_type disk_i;
  int n_errors = 0, n_tests = 0, cycles = 0, n_steps = 0, n_sect = 0, n_host = 0;

  fdcsc_core uut (.sys_clk_i, .reset_i, .cmd_valid_i, .cmd_byte_i, .cmd_ready_o,
    .disk_valid_i, .disk_i, .disk_ready_o, .host_valid_i, .host_byte_i, .host_ready_o,
    .terminal_count_in_i, .scan_wildcard_enable_i, .present_track_i, .sector_req_o,
    .sector_num_o, .res_valid_o, .res_byte_o, .res_ready_i, .step_o, .step_dir_in_o,
    .drive_busy_o, .seek_done_o);
  fdcsc_disk_model #(.SEC_LEN(4)) disk_model (.sys_clk_i, .reset_i,
    .sector_req_i(sector_req_o), .disk_ready_i(disk_ready_o), .first_byte_i(first_b),
    .rest_byte_i(rest_b), .deleted_i(del), .disk_valid_o(disk_valid_i), .disk_o(disk_i));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (sector_req_o === 1'b1) begin
      sect_log[n_sect[3:0]] <= sector_num_o;
      n_sect <= n_sect + 1;
      if (tc_arm) terminal_count_in_i <= 1'b1;
    end
    if (host_ready_o === 1'b1 && host_valid_i === 1'b1) n_host <= n_host + 1;
    if (step_o === 1'b1) begin
      n_steps <= n_steps + 1;
      check("step dir", {7'h00, step_dir_in_o}, {7'h00, exp_dir});
    end
    if (cycles == TMO) begin
      n_errors++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    cmd_valid_i <= 1'b1;
    cmd_byte_i <= b;
    @(posedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && k < 5000) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= 5000) n_errors++;
  endtask

  task automatic scan(input logic [4:0] op, input logic sk, input logic [7:0] sec, last_sector_number, stp,
                      input logic [1:0] st2, input int n);
    logic [7:0] cmd [9];
    int r;
    int k;
    cmd = '{{2'b01, sk, op}, 8'h01, 8'h07, 8'h00, sec, 8'h02, last_sector_number, 8'h1B, stp};
    n_sect = 0;
    n_host = 0;
    r = 0;
    k = 0;
    foreach (cmd[i]) send(cmd[i]);
    cmd_valid_i <= 1'b0;
    while (r < RES_BYTES && k < 20000) begin
      @(posedge sys_clk_i);
      k++;
      if (res_valid_o === 1'b1) begin
        res[r] = res_byte_o;
        r++;
      end
    end
    if (r < RES_BYTES) n_errors++;
    check("st0", res[0], 8'h01);
    check("st1", res[1], 8'h00);
    check("st2", res[2] & 8'h0C, {4'h0, st2, 2'b00});
    check("trk", res[3], 8'h07);
    check("head", res[4], 8'h00);
    check("size", res[6], 8'h02);
    check("sec0", sect_log[0], sec);
    check("nsec", n_sect[7:0], n[7:0]);
    check("nhost", n_host[7:0], del ? 8'h00 : 8'(4 * n));
    if (n == 1) check("sec", res[5], sec);
    if (n > 1) check("sec1", sect_log[1], sec + stp);
  endtask

  // op, first byte, other bytes, host byte, wildcard, satisfied/not
  task automatic t_compare();
    logic [31:0] tbl [11] = '{
      {OP_SCAN_EQ, 8'h5A, 8'h5A, 8'h5A, 1'b0, 2'b10},
      {OP_SCAN_EQ, 8'h5A, 8'h5A, 8'h5B, 1'b0, 2'b01},
      {OP_SCAN_LE, 8'h10, 8'h30, 8'h20, 1'b0, 2'b00},
      {OP_SCAN_LE, 8'h30, 8'h10, 8'h20, 1'b0, 2'b01},
      {OP_SCAN_LE, 8'h20, 8'h20, 8'h20, 1'b0, 2'b10},
      {OP_SCAN_HE, 8'h30, 8'h30, 8'h20, 1'b0, 2'b00},
      {OP_SCAN_HE, 8'h10, 8'h10, 8'h20, 1'b0, 2'b01},
      {OP_SCAN_HE, 8'h90, 8'h90, 8'h20, 1'b0, 2'b00},
      {OP_SCAN_EQ, 8'h5A, 8'h5A, 8'hFF, 1'b1, 2'b10},
      {OP_SCAN_EQ, 8'hFF, 8'hFF, 8'h33, 1'b1, 2'b10},
      {OP_SCAN_EQ, 8'h5A, 8'h5A, 8'hFF, 1'b0, 2'b01}};
    foreach (tbl[i]) begin
      {first_b, rest_b, host_byte_i, scan_wildcard_enable_i} <= tbl[i][26:2];
      scan(tbl[i][31:27], 1'b0, 8'h03, 8'h03, 8'h01, tbl[i][1:0], 1);
    end
    scan_wildcard_enable_i <= 1'b0;
  endtask

  task automatic t_step_skip_tc();
    first_b <= 8'h5A;
    rest_b <= 8'h5A;
    host_byte_i <= 8'h33;
    scan(OP_SCAN_EQ, 1'b0, 8'h01, 8'h05, 8'h02, 2'b01, 3);
    del <= 1'b1;
    scan(OP_SCAN_EQ, 1'b1, 8'h01, 8'h02, 8'h01, 2'b10, 2);
    del <= 1'b0;
    tc_arm = 1'b1;
    scan(OP_SCAN_EQ, 1'b0, 8'h01, 8'h09, 8'h01, 2'b01, 1);
    tc_arm = 1'b0;
    terminal_count_in_i <= 1'b0;
  endtask

  task automatic t_seek(input logic [7:0] from, to, input logic [1:0] drv);
    int k;
    k = 0;
    present_track_i <= from;
    exp_dir = (to > from);
    n_steps = 0;
    send(OP_SEEK);
    send({6'h00, drv});
    send(to);
    cmd_valid_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check("busy", {4'h0, drive_busy_o}, 8'h01 << drv);
    while (seek_done_o !== 1'b1 && k < 5000) begin
      @(posedge sys_clk_i);
      k++;
    end
    repeat (2) @(posedge sys_clk_i);
    if (k >= 5000) n_errors++;
    check("steps", n_steps[7:0], (to > from) ? to - from : from - to);
    check("idle", {4'h0, drive_busy_o}, 8'h00);
  endtask

  initial begin
    reset_i = 1'b1;
    {cmd_valid_i, terminal_count_in_i, scan_wildcard_enable_i, del, tc_arm} = '0;
    {cmd_byte_i, host_byte_i, present_track_i, first_b, rest_b} = '0;
    host_valid_i = 1'b1;
    res_ready_i = 1'b1;
    exp_dir = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    t_compare();
    t_step_skip_tc();
    t_seek(8'h05, 8'h08, 2'd1);
    t_seek(8'h08, 8'h06, 2'd2);
    summarize();
  end
endmodule
`default_nettype wire
